// ### logic/dispmem_regs.svh
`ifndef DISPMEM_REGS_SVH
`define DISPMEM_REGS_SVH

// Register byte offsets
`define STRAP_REG_OFS 8'h00
`define CTRL_REG_OFS 8'h04
`define STATUS_REG_OFS 8'h08

// Strap readback field positions
`define STRAP_TYPE_BIT 7
`define STRAP_HI_BIT 6
`define STRAP_LO_BIT 5

// Display control fields
`define CTRL_SIMUL_BIT 0
`define CTRL_DUALSTN_BIT 1
`define CTRL_RESET 2'h0

// Status fields
`define STAT_VALID_BIT 0
`define STAT_MODE2_BIT 1
`define STAT_FB_BIT 2
`define STAT_WIDE_BIT 3

// Strap patterns, type/hi/lo
`define STRAP_MODE1 3'h5
`define STRAP_MODE2 3'h4

// Timing counts in clk_i cycles
`define SETTLE_CYCLES 2'h2
`define CAS_CYCLES 2'h3

`endif

// ### logic/dispmem_pkg.sv
package dispmem_pkg;

	typedef enum logic [1:0] {
		mode_none,
		mode_one,
		mode_two
	} mem_mode_type;

	typedef enum logic [2:0] {
		st_idle,
		st_row,
		st_col_a,
		st_col_b,
		st_done
	} mem_state_type;

	typedef struct packed {
		logic mem_type;
		logic cfg_hi;
		logic cfg_lo;
	} strap_type;

	typedef struct packed {
		logic req;
		logic we;
		logic [17:0] addr;
		logic [31:0] wdata;
	} mem_req_type;

	typedef struct packed {
		logic ras_n;
		logic cas_lo_n;
		logic cas_hi_n;
		logic we_n;
		logic oe_n;
		logic [8:0] ma;
	} dram_ctl_type;

endpackage

// ### logic/display_memory_mode_config.sv
`include "dispmem_regs.svh"

// Summary of operation
// - Memory mode is chosen from three straps only at reset, held after.
// - Software reads the three strap values at bits 7, 6 and 5.
// - Mode 1 drives and samples a 16-bit display memory data path.
// - Mode 2 uses a 32-bit path unless one bank is the frame buffer.
// - Mode 2 gives one bank to LCD for simultaneous or dual STN.
// - CRT-only or LCD-only: 16-bit in mode 1, 32-bit in mode 2.
module display_memory_mode_config (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Configuration strap pins
	input wire dispmem_pkg::strap_type strap_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Display memory request port
	input wire dispmem_pkg::mem_req_type mem_req_i,
	output logic mem_ack_o,
	output logic [31:0] mem_rdata_o,
	// DRAM pins
	output dispmem_pkg::dram_ctl_type dram_o,
	input wire logic [31:0] dram_dq_i,
	output logic [31:0] dram_dq_o,
	output logic [1:0] dram_dq_oe_o
);

	// Strap pattern decode, shared by capture and checks
	function automatic dispmem_pkg::mem_mode_type
			decode_mode(input dispmem_pkg::strap_type s);
		if (s == `STRAP_MODE1) begin
			decode_mode = dispmem_pkg::mode_one;
		end else if (s == `STRAP_MODE2) begin
			decode_mode = dispmem_pkg::mode_two;
		end else begin
			decode_mode = dispmem_pkg::mode_none;
		end
	endfunction

	dispmem_pkg::strap_type strap_meta;
	dispmem_pkg::strap_type strap_sync;
	dispmem_pkg::strap_type strap_held;
	dispmem_pkg::mem_mode_type mode;
	dispmem_pkg::mem_state_type state;
	logic [1:0] settle_cnt;
	logic latched;
	logic simul;
	logic dual_stn;
	logic fb_active;
	logic wide_path;
	logic wide_q;
	logic we_q;
	logic [17:0] addr_q;
	logic [31:0] wdata_q;
	logic [1:0] cas_cnt;
	logic [31:0] dq_meta;
	logic [31:0] dq_sync;
	logic start;
	logic cas_last;
	logic [31:0] status;

	// Straps are pins: two flops before anything looks at them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_meta <= 3'h0;
			strap_sync <= 3'h0;
		end else if (ce_i) begin
			strap_meta <= strap_i;
			strap_sync <= strap_meta;
		end
	end

	// Capture once after the synchroniser has filled; never again
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			settle_cnt <= 2'h0;
			latched <= 1'b0;
			strap_held <= 3'h0;
			mode <= dispmem_pkg::mode_none;
		end else if (ce_i && !latched) begin
			if (settle_cnt == `SETTLE_CYCLES) begin
				latched <= 1'b1;
				strap_held <= strap_sync;
				mode <= decode_mode(strap_sync);
			end else begin
				settle_cnt <= settle_cnt + 2'h1;
			end
		end
	end

	// Frame buffer bank only exists in mode 2
	assign fb_active = (mode == dispmem_pkg::mode_two) &&
		(simul || dual_stn);
	// Plain CRT or LCD in mode 2 takes both banks
	assign wide_path = (mode == dispmem_pkg::mode_two) &&
		!fb_active;

	// Unsupported strap patterns leave the memory port dead
	assign start = (state == dispmem_pkg::st_idle) && latched &&
		mem_req_i.req && (mode != dispmem_pkg::mode_none);
	assign cas_last = (cas_cnt == `CAS_CYCLES - 2'h1);

	// Width is frozen per access so a control write mid-access is safe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wide_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= 18'h0;
			wdata_q <= 32'h0;
		end else if (ce_i && start) begin
			wide_q <= wide_path;
			we_q <= mem_req_i.we;
			addr_q <= mem_req_i.addr;
			wdata_q <= mem_req_i.wdata;
		end
	end

	// Access sequencer: row, one or two column phases, precharge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= dispmem_pkg::st_idle;
			cas_cnt <= 2'h0;
		end else if (ce_i) begin
			case (state)
			dispmem_pkg::st_idle: begin
				if (start) begin
					state <= dispmem_pkg::st_row;
				end
			end
			dispmem_pkg::st_row: begin
				state <= dispmem_pkg::st_col_a;
				cas_cnt <= 2'h0;
			end
			dispmem_pkg::st_col_a: begin
				if (cas_last) begin
					cas_cnt <= 2'h0;
					state <= wide_q ? dispmem_pkg::st_done :
						dispmem_pkg::st_col_b;
				end else begin
					cas_cnt <= cas_cnt + 2'h1;
				end
			end
			dispmem_pkg::st_col_b: begin
				if (cas_last) begin
					cas_cnt <= 2'h0;
					state <= dispmem_pkg::st_done;
				end else begin
					cas_cnt <= cas_cnt + 2'h1;
				end
			end
			dispmem_pkg::st_done: begin
				state <= dispmem_pkg::st_idle;
			end
			default: begin
				state <= dispmem_pkg::st_idle;
			end
			endcase
		end
	end

	// DRAM read data is off-chip: two flops, then CAS held long enough
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dq_meta <= 32'h0;
			dq_sync <= 32'h0;
		end else if (ce_i) begin
			dq_meta <= dram_dq_i;
			dq_sync <= dq_meta;
		end
	end

	// Read data assembly; narrow reads fill the word in two halves
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_rdata_o <= 32'h0;
		end else if (ce_i && !we_q && cas_last) begin
			if (state == dispmem_pkg::st_col_a) begin
				mem_rdata_o[15:0] <= dq_sync[15:0];
				if (wide_q) begin
					mem_rdata_o[31:16] <= dq_sync[31:16];
				end
			end else if (state == dispmem_pkg::st_col_b) begin
				mem_rdata_o[31:16] <= dq_sync[15:0];
			end
		end
	end

	// Write data lanes; high lanes only ever driven on the wide path
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dram_dq_o <= 32'h0;
			dram_dq_oe_o <= 2'h0;
		end else if (ce_i) begin
			if (state == dispmem_pkg::st_row && we_q) begin
				dram_dq_o <= wdata_q;
				dram_dq_oe_o <= {wide_q, 1'b1};
			end else if (state == dispmem_pkg::st_col_a && cas_last &&
					!wide_q && we_q) begin
				dram_dq_o <= {16'h0, wdata_q[31:16]};
				dram_dq_oe_o <= 2'h1;
			end else if (state == dispmem_pkg::st_done ||
					state == dispmem_pkg::st_idle) begin
				dram_dq_oe_o <= 2'h0;
			end
		end
	end

	// Row/column split differs between 32-bit and 16-bit words
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dram_o <= {5'h1f, 9'h0};
		end else if (ce_i) begin
			dram_o.we_n <= !(we_q && state != dispmem_pkg::st_idle &&
				state != dispmem_pkg::st_done);
			// Output enable opens with the first CAS, so the read word
			// has passed both sync flops by the third CAS edge
			dram_o.oe_n <= !(!we_q && (state == dispmem_pkg::st_row ||
				state == dispmem_pkg::st_col_a ||
				state == dispmem_pkg::st_col_b));
			case (state)
			dispmem_pkg::st_idle: begin
				dram_o.ras_n <= !start;
				dram_o.cas_lo_n <= 1'b1;
				dram_o.cas_hi_n <= 1'b1;
				dram_o.ma <= wide_path ? mem_req_i.addr[17:9] :
					mem_req_i.addr[16:8];
			end
			dispmem_pkg::st_row: begin
				dram_o.cas_lo_n <= 1'b0;
				dram_o.cas_hi_n <= !wide_q;
				dram_o.ma <= wide_q ? addr_q[8:0] :
					{addr_q[7:0], 1'b0};
			end
			dispmem_pkg::st_col_a: begin
				if (cas_last) begin
					dram_o.ma <= {addr_q[7:0], 1'b1};
					dram_o.ras_n <= wide_q;
					dram_o.cas_hi_n <= 1'b1;
				end
			end
			dispmem_pkg::st_col_b: begin
				if (cas_last) begin
					dram_o.ras_n <= 1'b1;
					dram_o.cas_lo_n <= 1'b1;
				end
			end
			default: begin
				dram_o.ras_n <= 1'b1;
				dram_o.cas_lo_n <= 1'b1;
				dram_o.cas_hi_n <= 1'b1;
			end
			endcase
		end
	end

	assign mem_ack_o = (state == dispmem_pkg::st_done) && ce_i;

	// Display control, steers the bank split in mode 2
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{dual_stn, simul} <= `CTRL_RESET;
		end else if (ce_i && cyc_i && stb_i && we_i && !ack_o &&
				adr_i == `CTRL_REG_OFS && sel_i[0]) begin
			simul <= dat_i[`CTRL_SIMUL_BIT];
			dual_stn <= dat_i[`CTRL_DUALSTN_BIT];
		end
	end

	// Status view of the applied configuration
	always_comb begin
		status = 32'h0;
		status[`STAT_VALID_BIT] = (mode != dispmem_pkg::mode_none);
		status[`STAT_MODE2_BIT] = (mode == dispmem_pkg::mode_two);
		status[`STAT_FB_BIT] = fb_active;
		status[`STAT_WIDE_BIT] = wide_path;
	end

	// One wait state; unmapped addresses ack with zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else if (ce_i) begin
			ack_o <= cyc_i && stb_i && !ack_o;
			dat_o <= 32'h0;
			if (cyc_i && stb_i && !ack_o && !we_i) begin
				case (adr_i)
				`STRAP_REG_OFS: begin
					dat_o[`STRAP_TYPE_BIT] <= strap_held.mem_type;
					dat_o[`STRAP_HI_BIT] <= strap_held.cfg_hi;
					dat_o[`STRAP_LO_BIT] <= strap_held.cfg_lo;
				end
				`CTRL_REG_OFS: begin
					dat_o[`CTRL_SIMUL_BIT] <= simul;
					dat_o[`CTRL_DUALSTN_BIT] <= dual_stn;
				end
				`STATUS_REG_OFS: begin
					dat_o <= status;
				end
				default: begin
					dat_o <= 32'h0;
				end
				endcase
			end
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i || !ce_i);

	// Narrow access: two CAS phases on the low lanes only
	sequence narrow_start_s;
		state == dispmem_pkg::st_row && !wide_q;
	endsequence
	sequence narrow_cols_s;
		(!dram_o.cas_lo_n && dram_o.cas_hi_n) [*3] ##1
		(state == dispmem_pkg::st_col_b);
	endsequence
	sequence wide_start_s;
		state == dispmem_pkg::st_row && wide_q;
	endsequence
	sequence wide_cols_s;
		(!dram_o.cas_lo_n && !dram_o.cas_hi_n) [*3] ##1
		(state == dispmem_pkg::st_done);
	endsequence

	strap_hold_a: assert property (
		latched |=> latched && $stable(strap_held) && $stable(mode))
		else $error("strap capture changed after reset");

	readback_bits_a: assert property (
		cyc_i && stb_i && !ack_o && !we_i && adr_i == `STRAP_REG_OFS
		|=> ack_o && dat_o[7:5] == strap_held && dat_o[4:0] == 5'h0)
		else $error("strap readback wrong");

	narrow_path_a: assert property (
		narrow_start_s |=> narrow_cols_s)
		else $error("narrow access not two low-lane phases");

	wide_path_a: assert property (
		wide_start_s |=> wide_cols_s)
		else $error("wide access not one two-lane phase");

	fb_bank_a: assert property (
		mode == dispmem_pkg::mode_two && (simul || dual_stn)
		|-> !wide_path && !dram_dq_oe_o[1] || wide_q)
		else $error("frame buffer bank used for display path");

	plain_width_a: assert property (
		start |=> wide_q == ($past(mode) == dispmem_pkg::mode_two &&
		!$past(simul) && !$past(dual_stn)))
		else $error("access width wrong for display type");

	strap_decode_a: assert property (
		latched |-> mode == decode_mode(strap_held) &&
		(mode != dispmem_pkg::mode_none ||
		state == dispmem_pkg::st_idle))
		else $error("strap decode wrong");

endmodule

// ### tb/dram_model.sv
module dram_model (
	// Clock
	input wire logic clk_i,
	// Controller side pins
	input wire dispmem_pkg::dram_ctl_type dram_i,
	input wire logic [31:0] dq_i,
	input wire logic [1:0] dq_oe_i,
	output logic [31:0] dq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Low lanes bank and high lanes bank, 256K words of 16 bits each
	logic [15:0] bank_a [0:262143];
	logic [15:0] bank_b [0:262143];
	logic [8:0] row;
	logic ras_q = 1'b1;
	logic [31:0] last = 32'h0;
	// Row taken on the falling RAS, written word lanes on each CAS cycle
	always @(posedge clk_i) begin
		ras_q <= dram_i.ras_n;
		if (ras_q && !dram_i.ras_n)
			row <= dram_i.ma;
		if (!dram_i.ras_n && !dram_i.we_n && !dram_i.cas_lo_n && dq_oe_i[0])
			bank_a[{row, dram_i.ma}] <= dq_i[15:0];
		if (!dram_i.ras_n && !dram_i.we_n && !dram_i.cas_hi_n && dq_oe_i[1])
			bank_b[{row, dram_i.ma}] <= dq_i[31:16];
		last <= dq_o;
	end
	// Idle lanes flip away from the last value so stale data never matches
	assign dq_o[15:0] = (!dram_i.oe_n && !dram_i.cas_lo_n) ?
		bank_a[{row, dram_i.ma}] : ~last[15:0];
	assign dq_o[31:16] = (!dram_i.oe_n && !dram_i.cas_hi_n) ?
		bank_b[{row, dram_i.ma}] : ~last[31:16];
endmodule

// ### tb/tb_display_memory_mode_config.sv
`include "dispmem_regs.svh"
module tb_display_memory_mode_config;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0, dat_o, mem_rdata_o, dq_in, dq_out, d;
	logic ack_o, mem_ack_o, hi_used = 0, hi_clr = 0, ok;
	logic [1:0] dq_oe;
	dispmem_pkg::strap_type strap_i = 3'h5;
	dispmem_pkg::mem_req_type mem_req_i = '0;
	dispmem_pkg::dram_ctl_type dram_o;
	int fail_count = 0, tests_run = 0;
	display_memory_mode_config i_dut (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(1'b1), .strap_i(strap_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .mem_req_i(mem_req_i),
		.mem_ack_o(mem_ack_o), .mem_rdata_o(mem_rdata_o), .dram_o(dram_o),
		.dram_dq_i(dq_in), .dram_dq_o(dq_out), .dram_dq_oe_o(dq_oe));
	dram_model i_mem (.clk_i(clk_i), .dram_i(dram_o), .dq_i(dq_out),
		.dq_oe_i(dq_oe), .dq_o(dq_in));
	// 200 MHz clock
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	// Any activity on the high lanes is remembered until cleared
	always @(posedge clk_i) begin
		if (hi_clr)
			hi_used <= 1'b0;
		else if (dq_oe[1] === 1'b1 || dram_o.cas_hi_n === 1'b0)
			hi_used <= 1'b1;
	end
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Straps held from reset through the capture edges
	task automatic do_reset(input logic [2:0] s);
		strap_i <= s;
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask
	// Classic Wishbone cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= wd;
		for (int n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (ack_o === 1'b1)
				break;
			if (n == 19) begin
				fail_count++;
				summarize();
			end
		end
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	// Display memory access; a refused request only reports no answer
	task automatic mem(input logic w, input logic [17:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic got);
		@(posedge clk_i);
		mem_req_i <= {1'b1, w, a, wd};
		got = 1'b0;
		for (int n = 0; n < 30 && !got; n++) begin
			@(posedge clk_i);
			got = (mem_ack_o === 1'b1);
		end
		rd = mem_rdata_o;
		mem_req_i <= '0;
	endtask
	// Write then read back one word, noting high lane use
	task automatic word(input logic [17:0] a, input logic [31:0] v,
		input logic hi);
		hi_clr <= 1'b1;
		@(posedge clk_i);
		hi_clr <= 1'b0;
		mem(1'b1, a, v, d, ok);
		check("write answered", 1, ok);
		mem(1'b0, a, 32'h0, d, ok);
		check("read data", v, d);
		check("high lanes used", hi, hi_used);
	endtask
	initial begin
		do_reset(`STRAP_MODE1);
		wb(0, `STRAP_REG_OFS, 0, d);
		check("strap readback", 32'ha0, d);
		wb(0, `STATUS_REG_OFS, 0, d);
		check("status", 32'h1, d);
		word(18'h00123, 32'hdeadbeef, 1'b0);
		strap_i <= 3'h4;
		wb(0, `STRAP_REG_OFS, 0, d);
		check("strap held", 32'ha0, d);
		wb(0, `STATUS_REG_OFS, 0, d);
		check("mode held", 32'h1, d);
		wb(1, `STRAP_REG_OFS, 32'hff, d);
		wb(0, `STRAP_REG_OFS, 0, d);
		check("strap read only", 32'ha0, d);
		wb(0, 8'h0c, 0, d);
		check("unmapped", 32'h0, d);
		$display("test mode 1 done");
		do_reset(`STRAP_MODE2);
		wb(0, `STRAP_REG_OFS, 0, d);
		check("strap readback", 32'h80, d);
		wb(0, `STATUS_REG_OFS, 0, d);
		check("status", 32'hb, d);
		word(18'h2a5a5, 32'h12345678, 1'b1);
		// Simultaneous display, then dual STN panel
		for (int i = 1; i < 3; i++) begin
			wb(1, `CTRL_REG_OFS, i, d);
			wb(0, `STATUS_REG_OFS, 0, d);
			check("frame buffer status", 32'h7, d);
			word(18'h01f00 + i, 32'hc0de0000 + i, 1'b0);
		end
		wb(1, `CTRL_REG_OFS, 0, d);
		wb(0, `STATUS_REG_OFS, 0, d);
		check("status restored", 32'hb, d);
		$display("test mode 2 done");
		do_reset(3'h7);
		wb(0, `STRAP_REG_OFS, 0, d);
		check("unsupported readback", 32'he0, d);
		wb(0, `STATUS_REG_OFS, 0, d);
		check("unsupported status", 32'h0, d);
		mem(1'b0, 18'h00010, 32'h0, d, ok);
		check("unsupported refused", 0, ok);
		$display("test unsupported straps done");
		summarize();
	end
endmodule
